// [rtl/ega_compat_register_bank.sv]
// ega compatibility register bank on the byte i/o port bus
module ega_compat_register_bank (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// host i/o port bus
	input wire ega_compat_pkg::io_req_s io_i,
	output logic [7:0] io_rdata_o,
	output logic io_rvalid_o,
	// memory data lines for straps
	input wire logic [15:0] memory_data_lines_i,
	// display side state
	input wire ega_compat_pkg::display_state_s disp_i,
	input wire logic [7:0] attr_code_i,
	input wire logic [3:0] config_i,
	// control outputs
	output logic drivers_off_o,
	output ega_compat_pkg::video_clock_e video_clock_o,
	output logic ega_mode_o,
	output logic monitor_type_strap_bit_o,
	output logic [1:0] font_table_o,
	output logic [7:0] misc_output_control_o,
	output logic [7:0] sequencer_clocking_mode_o,
	output logic [7:0] ext_reg_eleven_o,
	output logic [7:0] ext_reg_fourteen_o,
	output logic [7:0] ext_reg_fifteen_o,
	output logic [4:0] crtc_index_o,
	output logic crtc_wr_o,
	output logic [7:0] attr_index_o,
	output logic attr_wr_o
);
	import ega_compat_pkg::*;
	// ****************
	// state
	// ****************
	typedef struct packed {
		logic [7:0] misc;
		logic [7:0] seq_index;
		logic [7:0] clocking_mode;
		logic [7:0] char_map;
		logic [7:0] feature;
		logic [7:0] ext_index;
		logic [7:0] ext_two;
		logic [7:0] ext_four;
		logic [3:0] ext_eleven_low;
		logic [7:0] ext_fourteen;
		logic [7:0] ext_fifteen;
		logic [4:0] crtc_index;
		logic attr_flip;
		logic [7:0] attr_index;
		logic attr_wr;
		logic crtc_wr;
		logic [7:0] rdata;
		logic rvalid;
		logic [1:0] font;
		logic [1:0] sync_sw;
		logic [1:0] sync_trig;
	} bank_state_s;
	bank_state_s st;
	bank_state_s next_st;
	logic mon_strap;
	logic [3:0] switches;
	logic strap_done;
	logic color_io;
	logic [9:0] crtc_index_port;
	logic [9:0] crtc_data_port;
	logic [9:0] status_port;
	logic ega_compat;
	logic [7:0] status0;
	logic [7:0] status1;
	logic [7:0] ext_eleven;
	// ****************
	// strap capture
	// ****************
	ega_strap_latch strap_u (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.memory_data_lines_i(memory_data_lines_i),
		.monitor_type_strap_bit_o(mon_strap),
		.switches_o(switches),
		.done_o(strap_done)
	);
	assign ext_eleven = {switches, st.ext_eleven_low}; // R4
	// ****************
	// port decode
	// ****************
	assign color_io = st.misc[color_io_bit];
	assign crtc_index_port = color_io ? port_crtc_index_color : port_crtc_index_mono; // R10
	assign crtc_data_port = color_io ? port_crtc_data_color : port_crtc_data_mono; // R10
	assign status_port = color_io ? port_status_color : port_status_mono; // R10
	assign ega_compat = st.ext_four[ega_compat_bit]; // R3
	// ****************
	// status readback
	// ****************
	always_comb begin
		status0 = {disp_i.display_inactive, 3'h0, status0_low_ones}; // R15
		if (ega_compat) begin
			status0[switch_lsb] = |switches; // R5
		end
		status1 = 8'h40; // R15
		status1[5:3] = 3'h0;
		status1[2] = st.sync_sw[1]; // R16
		status1[1] = st.sync_trig[1]; // R17
		status1[0] = disp_i.vert_retrace;
	end
	// ****************
	// access engine
	// ****************
	always_comb begin
		next_st = st;
		next_st.attr_wr = 1'b0;
		next_st.crtc_wr = 1'b0;
		next_st.rvalid = 1'b0;
		next_st.sync_sw = {st.sync_sw[0], disp_i.pen_switch_open};
		next_st.sync_trig = {st.sync_trig[0], disp_i.pen_trigger};
		next_st.font = attr_code_i[attr_map_bit] ? st.char_map[3:2] : st.char_map[1:0]; // R19 R20
		if (io_i.wr) begin
			if (io_i.addr == port_misc) begin
				next_st.misc = io_i.wdata; // R9
			end else if (io_i.addr == port_attr_a || io_i.addr == port_attr_b) begin
				next_st.attr_flip = ~st.attr_flip; // R12
				if (!st.attr_flip) begin
					next_st.attr_index = io_i.wdata;
				end else begin
					next_st.attr_wr = 1'b1;
				end
			end else if (io_i.addr == port_seq_index) begin
				next_st.seq_index = io_i.wdata;
			end else if (io_i.addr == port_seq_data) begin
				if (st.seq_index == seq_clocking_mode_idx) begin
					next_st.clocking_mode = io_i.wdata;
				end else if (st.seq_index == seq_char_map_idx) begin
					next_st.char_map = io_i.wdata; // R19
				end
			end else if (io_i.addr == port_ext_index) begin
				next_st.ext_index = io_i.wdata;
			end else if (io_i.addr == port_ext_data) begin
				case (st.ext_index)
					ext_two_idx: next_st.ext_two = io_i.wdata; // R2
					ext_four_idx: next_st.ext_four = io_i.wdata; // R3
					ext_eleven_idx: next_st.ext_eleven_low = io_i.wdata[3:0]; // R6
					ext_fourteen_idx: next_st.ext_fourteen = io_i.wdata; // R6
					ext_fifteen_idx: next_st.ext_fifteen = io_i.wdata;
					default: next_st.ext_index = st.ext_index;
				endcase
			end else if (io_i.addr == crtc_index_port) begin
				next_st.crtc_index = io_i.wdata[4:0];
			end else if (io_i.addr == crtc_data_port) begin
				next_st.crtc_wr = 1'b1;
			end else if (io_i.addr == status_port) begin
				next_st.feature = io_i.wdata; // R18
			end
		end else if (io_i.rd) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = zero_byte; // R22
			if (io_i.addr == port_misc) begin
				next_st.rdata = status0; // R9
			end else if (io_i.addr == status_port) begin
				next_st.rdata = status1;
				next_st.attr_flip = 1'b0;
			end else if (io_i.addr == crtc_data_port) begin
				if (st.crtc_index >= crtc_rw_first && st.crtc_index <= crtc_rw_last) begin
					next_st.rdata = disp_i.crtc_rw_data; // R11
				end else if (st.crtc_index == crtc_pen_high_idx) begin
					next_st.rdata = disp_i.pen_high; // R11
				end else if (st.crtc_index == crtc_pen_low_idx) begin
					next_st.rdata = disp_i.pen_low; // R11
				end
			end else if (io_i.addr == port_ext_data) begin
				case (st.ext_index)
					ext_two_idx: next_st.rdata = st.ext_two;
					ext_four_idx: next_st.rdata = st.ext_four;
					ext_eleven_idx: next_st.rdata = ext_eleven;
					ext_fourteen_idx: next_st.rdata = st.ext_fourteen;
					ext_fifteen_idx: next_st.rdata = st.ext_fifteen;
					default: next_st.rdata = zero_byte;
				endcase
			end
		end
	end
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '0;
			st.misc <= misc_reset;
			st.ext_two <= ext_two_reset;
		end else begin
			st <= next_st;
		end
	end
	// ****************
	// outputs
	// ****************
	always_comb begin
		case (st.misc[clk_sel_lsb +: 2])
			2'h0: video_clock_o = clk_base; // R14
			2'h1: video_clock_o = config_i[config_alt_clock_bit] ? clk_base : clk_alt; // R14
			default: video_clock_o = config_i[config_alt_clock_bit] ? clk_base : clk_external; // R14
		endcase
	end
	assign drivers_off_o = st.misc[driver_off_bit]; // R13
	assign ega_mode_o = ~st.ext_two[ega_select_bit]; // R2
	assign monitor_type_strap_bit_o = mon_strap; // R1
	assign font_table_o = st.font;
	assign misc_output_control_o = st.misc;
	assign sequencer_clocking_mode_o = st.clocking_mode;
	assign ext_reg_eleven_o = ext_eleven;
	assign ext_reg_fourteen_o = st.ext_fourteen;
	assign ext_reg_fifteen_o = st.ext_fifteen;
	assign crtc_index_o = st.crtc_index;
	assign crtc_wr_o = st.crtc_wr;
	assign attr_index_o = st.attr_index;
	assign attr_wr_o = st.attr_wr;
	assign io_rdata_o = st.rdata;
	assign io_rvalid_o = st.rvalid;
	// ****************
	// checks
	// ****************
	misc_readback_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R9
		(io_i.rd && !io_i.wr && io_i.addr == port_misc) |=> (io_rvalid_o && io_rdata_o[3:0] == 4'hF))
		else $error("misc port read not status zero");
	read_no_effect_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R22
		(io_i.rd && !io_i.wr) |=> $stable(misc_output_control_o) && $stable(ext_reg_fourteen_o))
		else $error("read changed stored register");
	driver_disable_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R13
		(io_i.wr && io_i.addr == port_misc) |=> (drivers_off_o == $past(io_i.wdata[4])))
		else $error("driver disable not taken");
	ega_select_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R2
		(io_i.wr && io_i.addr == port_ext_data && st.ext_index == ext_two_idx)
		|=> (ega_mode_o == !$past(io_i.wdata[6])))
		else $error("ega select wrong");
	status_one_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R15
		(io_i.rd && !io_i.wr && io_i.addr == status_port) |=> (io_rdata_o[6] && !io_rdata_o[7]))
		else $error("status one fixed bits wrong");
	switch_status_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R5
		(io_i.rd && !io_i.wr && io_i.addr == port_misc && !ega_compat) |=> !io_rdata_o[4])
		else $error("switch bit shown without ega compat");
	clock_pick_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R14
		config_i[3] |-> video_clock_o == clk_base)
		else $error("alternate clock while config bit 3 set");
	attr_alias_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R12
		(io_i.wr && io_i.addr == port_attr_b && st.attr_flip) |=> attr_wr_o)
		else $error("attribute data at 3C1 ignored");
	font_pick_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R20
		attr_code_i[3] |=> font_table_o == $past(st.char_map[3:2]))
		else $error("map a not chosen");
	map_b_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R20
		!attr_code_i[attr_map_bit] |=> (font_table_o == $past(st.char_map[1:0])))
		else $error("map b not chosen");
	strap_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R4
		strap_done |=> $stable(ext_reg_eleven_o[7:4]))
		else $error("switch straps changed after capture");
	monitor_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R1
		strap_done |=> $stable(monitor_type_strap_bit_o))
		else $error("monitor strap changed after capture");
	switch_shown_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R5
		(io_i.rd && !io_i.wr && io_i.addr == port_misc && ega_compat)
		|=> (io_rdata_o[4] == (|$past(switches))))
		else $error("switch bit not shown with ega compat");
	crtc_pen_low_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R11
		(io_i.rd && !io_i.wr && io_i.addr == crtc_data_port && st.crtc_index == crtc_pen_low_idx)
		|=> (io_rdata_o == $past(disp_i.pen_low)))
		else $error("light pen low not read back");
	crtc_rw_read_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R11
		(io_i.rd && !io_i.wr && io_i.addr == crtc_data_port && st.crtc_index == crtc_rw_first)
		|=> (io_rdata_o == $past(disp_i.crtc_rw_data)))
		else $error("start address not read back");
	crtc_wo_read_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R11
		(io_i.rd && !io_i.wr && io_i.addr == crtc_data_port && st.crtc_index < crtc_rw_first)
		|=> (io_rdata_o == zero_byte))
		else $error("write-only crtc register read back");
	crtc_write_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R11
		(io_i.wr && io_i.addr == crtc_data_port) |=> crtc_wr_o)
		else $error("crtc data write not passed on");
	seq_read_zero_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R22
		(io_i.rd && !io_i.wr && io_i.addr == port_seq_data) |=> (io_rdata_o == zero_byte))
		else $error("write-only sequencer data read back");
	feature_inert_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R18
		(io_i.wr && io_i.addr == status_port)
		|=> ($stable(misc_output_control_o) && $stable(ext_reg_fifteen_o)))
		else $error("feature control write had an effect");
	flip_reset_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R12
		(io_i.rd && !io_i.wr && io_i.addr == status_port) |=> !st.attr_flip)
		else $error("status read did not reset attribute pairing");
	attr_index_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R12
		(io_i.wr && io_i.addr == port_attr_b && !st.attr_flip)
		|=> (attr_index_o == $past(io_i.wdata)))
		else $error("attribute index at 3C1 ignored");
	ext_fourteen_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R6
		(io_i.wr && io_i.addr == port_ext_data && st.ext_index == ext_fourteen_idx)
		|=> (ext_reg_fourteen_o == $past(io_i.wdata)))
		else $error("ext_reg_fourteen write lost");
	ext_eleven_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R6
		(io_i.wr && io_i.addr == port_ext_data && st.ext_index == ext_eleven_idx)
		|=> (ext_reg_eleven_o[3:0] == $past(io_i.wdata[3:0])))
		else $error("ext_reg_eleven write lost");
	clock_base_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R14
		(misc_output_control_o[3:2] == 2'h0) |-> (video_clock_o == clk_base))
		else $error("base clock not chosen");
	clock_alt_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R14
		(!config_i[config_alt_clock_bit] && misc_output_control_o[3:2] == 2'h1)
		|-> (video_clock_o == clk_alt))
		else $error("alternate clock not chosen");
	clock_ext_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R14
		(!config_i[config_alt_clock_bit] && misc_output_control_o[3])
		|-> (video_clock_o == clk_external))
		else $error("external clock not chosen");
	// ****************
	// covers
	// ****************
	pen_read_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
		io_i.rd && io_i.addr == crtc_data_port && st.crtc_index == crtc_pen_high_idx);
	ega_on_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i) $rose(ega_mode_o));
	alt_clock_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i) video_clock_o == clk_alt);
	switch_read_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
		io_i.rd && io_i.addr == port_misc && ega_compat);
	attr_data_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i) attr_wr_o);
endmodule

// [rtl/ega_compat_pkg.sv]
// constants and carriers for the ega compatibility register bank
// Behaviour
// R1 - strap on data line 11 latched at reset as monitor type; pull-up gives 0
// R2 - ega operation selected when ext_reg_two bit 6 is written 0
// R3 - ext_reg_four bit 1 set enables ega status readback
// R4 - straps on data lines 15:12 latch into ext_reg_eleven 7:4 after reset
// R5 - with ega compatibility set, status zero bit 4 returns latched switch
// R6 - software sets emulation, clock lock, dot lock and double scan bits
// R7 - ttl monitor software clears emulation, enables interrupt, sets low clock
// R8 - software locks extended registers then enables their read protection
// R9 - misc output write-only at 3C2; reads there return status zero
// R10 - wildcard port digit decodes B in mono modes, D in color modes
// R11 - crtc data write-only except 0C-0F read/write; 10,11 read light pen
// R12 - attribute index/data respond identically at 3C0 and 3C1
// R13 - misc output bit 4 set disables video drivers, clear activates them
// R14 - misc bits 3:2 pick video clock; alternates only if config bit 3 is 0
// R15 - status zero bits 3:0 read ones; status one bit 6 one, bit 7 unused
// R16 - status one bit 2 is light pen switch: 0 closed, 1 open
// R17 - status one bit 1 is light pen trigger latch: 1 set, 0 reset
// R18 - feature control write-only and all bits without function
// R19 - map select fields a 3:2 and b 1:0 choose an 8 Kbyte font region
// R20 - attribute bit 3 chooses between character map a and b
// R21 - software writes 0 to every bit without function
// R22 - reads of write-only locations never change stored contents
package ega_compat_pkg;
	// ****************
	// port addresses
	// ****************
	localparam logic [9:0] port_attr_a = 10'h3C0;
	localparam logic [9:0] port_attr_b = 10'h3C1;
	localparam logic [9:0] port_misc = 10'h3C2;
	localparam logic [9:0] port_seq_index = 10'h3C4;
	localparam logic [9:0] port_seq_data = 10'h3C5;
	localparam logic [9:0] port_ext_index = 10'h3CE;
	localparam logic [9:0] port_ext_data = 10'h3CF;
	localparam logic [9:0] port_crtc_index_mono = 10'h3B4;
	localparam logic [9:0] port_crtc_data_mono = 10'h3B5;
	localparam logic [9:0] port_status_mono = 10'h3BA;
	localparam logic [9:0] port_crtc_index_color = 10'h3D4;
	localparam logic [9:0] port_crtc_data_color = 10'h3D5;
	localparam logic [9:0] port_status_color = 10'h3DA;
	// ****************
	// register indices
	// ****************
	localparam logic [7:0] seq_clocking_mode_idx = 8'h01;
	localparam logic [7:0] seq_char_map_idx = 8'h03;
	localparam logic [7:0] ext_two_idx = 8'h0C;
	localparam logic [7:0] ext_four_idx = 8'h0E;
	localparam logic [7:0] ext_eleven_idx = 8'h2B;
	localparam logic [7:0] ext_fourteen_idx = 8'h2E;
	localparam logic [7:0] ext_fifteen_idx = 8'h2F;
	localparam logic [4:0] crtc_rw_first = 5'h0C;
	localparam logic [4:0] crtc_rw_last = 5'h0F;
	localparam logic [4:0] crtc_pen_high_idx = 5'h10;
	localparam logic [4:0] crtc_pen_low_idx = 5'h11;
	// ****************
	// field positions
	// ****************
	localparam int ega_select_bit = 6;
	localparam int ega_compat_bit = 1;
	localparam int driver_off_bit = 4;
	localparam int clk_sel_lsb = 2;
	localparam int color_io_bit = 0;
	localparam int switch_lsb = 4;
	localparam int strap_monitor_line = 11;
	localparam int strap_switch_lsb = 12;
	localparam int config_alt_clock_bit = 3;
	localparam int attr_map_bit = 3;
	// ****************
	// reset values and fixed constants
	// ****************
	localparam logic [7:0] misc_reset = 8'h00;
	localparam logic [7:0] ext_two_reset = 8'h40;
	localparam logic [7:0] zero_byte = 8'h00;
	localparam logic [3:0] status0_low_ones = 4'hF;
	localparam logic [2:0] dump_index = 3'h0;
	localparam logic [1:0] strap_wait_last = 2'h3;
	// ****************
	// types
	// ****************
	typedef enum logic [2:0] {
		clk_base = 3'b001,
		clk_alt = 3'b010,
		clk_external = 3'b100
	} video_clock_e;
	typedef struct packed {
		logic rd;
		logic wr;
		logic [9:0] addr;
		logic [7:0] wdata;
	} io_req_s;
	typedef struct packed {
		logic pen_switch_open;
		logic pen_trigger;
		logic vert_retrace;
		logic display_inactive;
		logic [7:0] pen_high;
		logic [7:0] pen_low;
		logic [7:0] crtc_rw_data;
	} display_state_s;
endpackage

// [rtl/ega_strap_latch.sv]
// strap capture after reset release
module ega_strap_latch (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// memory data lines
	input wire logic [15:0] memory_data_lines_i,
	// captured straps
	output logic monitor_type_strap_bit_o,
	output logic [3:0] switches_o,
	output logic done_o
);
	import ega_compat_pkg::*;
	typedef struct packed {
		logic [15:0] s1;
		logic [15:0] s2;
		logic mon;
		logic [3:0] sw;
		logic done;
		logic [1:0] wait_cnt;
	} strap_state_s;
	strap_state_s st;
	strap_state_s next_st;
	always_comb begin
		next_st = st;
		next_st.s1 = memory_data_lines_i;
		next_st.s2 = st.s1;
		if (!st.done) begin
			if (st.wait_cnt == strap_wait_last) begin
				next_st.done = 1'b1;
				next_st.mon = ~st.s2[strap_monitor_line]; // R1
				next_st.sw = st.s2[strap_switch_lsb +: 4]; // R4
			end else begin
				next_st.wait_cnt = st.wait_cnt + 2'h1;
			end
		end
	end
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign monitor_type_strap_bit_o = st.mon;
	assign switches_o = st.sw;
	assign done_o = st.done;
endmodule

// [test/io_host.sv]
// host processor model driving the byte i/o port bus
module io_host (
	// clock
	input wire logic mclk_i,
	// read answer
	input wire logic [7:0] rdata_i,
	input wire logic rvalid_i,
	// request
	output ega_compat_pkg::io_req_s io_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import ega_compat_pkg::*;
	initial io_o = '0;
	// ****************
	// bus cycles
	// ****************
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(negedge mclk_i);
		io_o <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(negedge mclk_i);
		io_o <= '0;
	endtask
	task automatic rd(input logic [9:0] a, output logic [7:0] d, output bit ok);
		@(negedge mclk_i);
		io_o <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(negedge mclk_i);
		io_o <= '0;
		ok = 1'b0;
		d = 8'h00;
		for (int i = 0; i < 3 && !ok; i++) begin
			if (rvalid_i === 1'b1) begin
				ok = 1'b1;
				d = rdata_i;
			end else begin
				@(negedge mclk_i);
			end
		end
	endtask
endmodule

// [test/ega_compat_register_bank_tb.sv]
// self-checking bench for the ega compatibility register bank
module ega_compat_register_bank_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import ega_compat_pkg::*;
	typedef struct packed {
		logic [7:0] misc;
		logic [3:0] cfg;
		logic drv;
		logic [2:0] clk;
	} row_s;
	logic mclk, rst_n;
	io_req_s io;
	logic [7:0] rdata;
	logic rvalid;
	logic [15:0] strap_lines;
	display_state_s disp;
	logic [7:0] attr_code;
	logic [3:0] config_bits;
	logic drv_off, ega_mode, mon_bit, crtc_wr, attr_wr;
	video_clock_e vclk;
	logic [1:0] font;
	logic [7:0] misc, seq_cm, e11, e14, e15, attr_idx;
	logic [4:0] crtc_idx;
	int num_errors = 0;
	int checked = 0;
	int crtc_pulses = 0;
	int attr_pulses = 0;
	row_s rows [6] = '{'{8'h00, 4'h0, 1'b0, clk_base}, '{8'h04, 4'h0, 1'b0, clk_alt},
		'{8'h08, 4'h0, 1'b0, clk_external}, '{8'h0C, 4'h0, 1'b0, clk_external},
		'{8'h10, 4'h0, 1'b1, clk_base}, '{8'h04, 4'h8, 1'b0, clk_base}};
	io_host i_host (.mclk_i(mclk), .rdata_i(rdata), .rvalid_i(rvalid), .io_o(io));
	ega_compat_register_bank i_dut (.mclk_i(mclk), .rst_n_i(rst_n), .io_i(io), .io_rdata_o(rdata),
		.io_rvalid_o(rvalid), .memory_data_lines_i(strap_lines), .disp_i(disp), .attr_code_i(attr_code),
		.config_i(config_bits), .drivers_off_o(drv_off), .video_clock_o(vclk), .ega_mode_o(ega_mode),
		.monitor_type_strap_bit_o(mon_bit), .font_table_o(font), .misc_output_control_o(misc),
		.sequencer_clocking_mode_o(seq_cm), .ext_reg_eleven_o(e11), .ext_reg_fourteen_o(e14),
		.ext_reg_fifteen_o(e15), .crtc_index_o(crtc_idx), .crtc_wr_o(crtc_wr), .attr_index_o(attr_idx),
		.attr_wr_o(attr_wr));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (crtc_wr === 1'b1) crtc_pulses++;
		if (attr_wr === 1'b1) attr_pulses++;
	end
	// ****************
	// helpers
	// ****************
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", n, e, g);
			num_errors++;
		end
	endtask
	task automatic rdc(input logic [9:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] d;
		bit ok;
		i_host.rd(a, d, ok);
		if (!ok) begin
			num_errors++;
			report_and_stop();
		end
		chk("io_rdata", e, d & m);
	endtask
	task automatic ext(input logic [7:0] idx, input logic [7:0] d);
		i_host.wr(port_ext_index, idx);
		i_host.wr(port_ext_data, d);
	endtask
	// ****************
	// main sequence
	// ****************
	initial begin
		rst_n = 1'b0;
		strap_lines = 16'hA000;
		disp = '{1'b1, 1'b1, 1'b0, 1'b0, 8'h12, 8'h34, 8'h5A};
		attr_code = 8'h00;
		config_bits = 4'h0;
		repeat (3) @(negedge mclk);
		rst_n = 1'b1;
		chk("ega_mode", 8'h00, ega_mode);
		chk("video_clock", clk_base, vclk);
		chk("misc", misc_reset, misc);
		repeat (6) @(negedge mclk);
		chk("monitor_bit", 8'h01, mon_bit);
		chk("switches", 8'h0A, e11[7:4]);
		ext(ext_two_idx, 8'h00);
		chk("ega_mode", 8'h01, ega_mode);
		rdc(port_misc, 8'h1F, 8'h0F);
		ext(ext_four_idx, 8'h02);
		rdc(port_misc, 8'h1F, 8'h1F);
		for (int i = 0; i < 6; i++) begin
			config_bits = rows[i].cfg;
			i_host.wr(port_misc, rows[i].misc);
			chk("drivers_off", rows[i].drv, drv_off);
			chk("video_clock", rows[i].clk, vclk);
		end
		config_bits = 4'h0;
		i_host.wr(port_misc, 8'h00);
		rdc(port_status_mono, 8'h7E, 8'h46);
		rdc(port_status_color, 8'hFF, 8'h00);
		i_host.wr(port_status_mono, 8'hFF);
		rdc(port_misc, 8'hFF, 8'h1F);
		chk("misc", 8'h00, misc);
		i_host.wr(port_misc, 8'h01);
		i_host.wr(port_crtc_index_color, 8'h0C);
		rdc(port_crtc_data_color, 8'hFF, 8'h5A);
		i_host.wr(port_crtc_index_color, 8'h10);
		rdc(port_crtc_data_color, 8'hFF, 8'h12);
		i_host.wr(port_crtc_index_color, 8'h11);
		chk("crtc_index", 8'h11, crtc_idx);
		rdc(port_crtc_data_color, 8'hFF, 8'h34);
		i_host.wr(port_crtc_index_color, 8'h00);
		rdc(port_crtc_data_color, 8'hFF, 8'h00);
		i_host.wr(port_crtc_data_color, 8'h5F);
		i_host.wr(port_crtc_data_mono, 8'h5F);
		@(negedge mclk);
		chk("crtc_pulses", 8'h01, crtc_pulses);
		rdc(port_status_color, 8'h7E, 8'h46);
		i_host.wr(port_attr_a, 8'h05);
		i_host.wr(port_attr_b, 8'h3F);
		i_host.wr(port_attr_b, 8'h07);
		chk("attr_index", 8'h07, attr_idx);
		i_host.wr(port_attr_a, 8'h2A);
		@(negedge mclk);
		chk("attr_pulses", 8'h02, attr_pulses);
		i_host.wr(port_seq_index, seq_char_map_idx);
		i_host.wr(port_seq_data, 8'h09);
		attr_code = 8'h08;
		repeat (2) @(negedge mclk);
		chk("font_table", 8'h02, font);
		attr_code = 8'h00;
		repeat (2) @(negedge mclk);
		chk("font_table", 8'h01, font);
		rdc(port_seq_data, 8'hFF, 8'h00);
		i_host.wr(port_seq_index, seq_clocking_mode_idx);
		i_host.wr(port_seq_data, 8'h01);
		chk("clocking_mode", 8'h01, seq_cm);
		ext(ext_eleven_idx, 8'h0D);
		ext(ext_fourteen_idx, 8'h40);
		chk("ext_eleven", 8'hAD, e11);
		chk("ext_fourteen", 8'h40, e14);
		ext(ext_eleven_idx, 8'h00);
		ext(ext_fourteen_idx, 8'h80);
		ext(ext_fifteen_idx, 8'h40);
		chk("ext_fifteen", 8'h40, e15);
		chk("ext_fourteen", 8'h80, e14);
		rdc(port_ext_data, 8'hFF, 8'h40);
		disp.pen_switch_open = 1'b0;
		disp.pen_trigger = 1'b0;
		repeat (4) @(negedge mclk);
		rdc(port_status_color, 8'h7E, 8'h40);
		strap_lines = 16'h0800;
		rst_n = 1'b0;
		@(negedge mclk);
		rst_n = 1'b1;
		repeat (6) @(negedge mclk);
		chk("monitor_bit", 8'h00, mon_bit);
		chk("ext_eleven", 8'h00, e11);
		report_and_stop();
	end
endmodule
